// ===== hw/oass_defines.svh
// constants for the operand/address size selector
`ifndef OASS_DEFINES_SVH
`define OASS_DEFINES_SVH
`define OASS_PFX_OPSIZE 8'h66
`define OASS_PFX_ADSIZE 8'h67
`define OASS_OFF_CTRL 32'h0000_0000
`define OASS_OFF_MODE 32'h0000_0004
`define OASS_OFF_INSN 32'h0000_0008
`define OASS_OFF_GATE 32'h0000_000c
`define OASS_OFF_STAT 32'h0000_0010
`define OASS_OFF_ADDR 32'h0000_0014
`define OASS_OFF_EAOUT 32'h0000_0018
`define OASS_OFF_LIMIT 32'h0000_001c
`define OASS_OFF_LIMCHK 32'h0000_0020
`define OASS_CTRL_CS_D 0
`define OASS_CTRL_SS_B 1
`define OASS_CTRL_DS_B 2
`define OASS_INSN_OPS 0
`define OASS_INSN_ADS 1
`define OASS_INSN_GO 2
`define OASS_INSN_STK 3
`define OASS_GATE_USE 0
`define OASS_GATE_32 1
`define OASS_ST_OP32 0
`define OASS_ST_AD32 1
`define OASS_ST_STK32 2
`define OASS_ST_RET32 3
`define OASS_ST_VALID 4
`define OASS_ST_PFXOP 5
`define OASS_ST_PFXAD 6
`define OASS_ST_LIMOK 7
`define OASS_MASK16 32'h0000_ffff
`define OASS_MASK32 32'hffff_ffff
`define OASS_RESET_CTRL 32'h0000_0000
`endif

// ===== hw/oass_pkg.sv
// types for the operand/address size selector
package oass_pkg;
  typedef enum logic [1:0] {
    OASS_MODE_REAL = 2'h0,
    OASS_MODE_PROT = 2'h1,
    OASS_MODE_V86 = 2'h3,
    OASS_MODE_SMS = 2'h2
  } oass_mode_e;
  typedef struct packed {
    logic op32;
    logic ad32;
  } oass_size_s;
endpackage

// ===== hw/oass_size_if.sv
// decode request and result between the top and the size decoder
`timescale 1ns/100ps
`default_nettype none
interface oass_size_if;
  import oass_pkg::*;
  logic cs_d;
  oass_mode_e mode;
  logic pfx_op;
  logic pfx_ad;
  logic gate_use;
  logic gate_32;
  oass_size_s size;
  logic xfer32;
  modport req (output cs_d, mode, pfx_op, pfx_ad, gate_use, gate_32, input size, xfer32);
  modport dec (input cs_d, mode, pfx_op, pfx_ad, gate_use, gate_32, output size, xfer32);
endinterface
`default_nettype wire

// ===== hw/oass_size_dec.sv
// combinational operand and address size decoder
`timescale 1ns/100ps
`default_nettype none
module oass_size_dec
  import oass_pkg::*;
(
  oass_size_if.dec sz
);
  logic dflt32;
  always_comb begin
    // descriptor-less modes default to 16
    dflt32 = (sz.mode == OASS_MODE_PROT) ? sz.cs_d : 1'b0;
    sz.size.op32 = dflt32 ^ sz.pfx_op;
    sz.size.ad32 = dflt32 ^ sz.pfx_ad;
    // gate type sets transfer size when a gate is in use, else operand size does
    sz.xfer32 = sz.gate_use ? sz.gate_32 : sz.size.op32;
  end
endmodule
`default_nettype wire

// ===== hw/oass_stack_sel.sv
// stack pointer width and effective address masking
`timescale 1ns/100ps
`default_nettype none
`include "oass_defines.svh"
module oass_stack_sel
  import oass_pkg::*;
(
  input wire logic ss_b,
  input wire logic implicit_stk,
  input wire logic ad32,
  input wire logic [31:0] offset,
  output logic stk32,
  output logic [31:0] ea
);
  always_comb begin
    // implicit pushes use ss flag, explicit use address size
    stk32 = implicit_stk ? ss_b : ad32;
    ea = (stk32 ? `OASS_MASK32 : `OASS_MASK16) & offset;
  end
endmodule
`default_nettype wire

// ===== hw/oass_top.sv
// operand/address size selector with ahb-lite register slave
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "oass_defines.svh"
module oass_top
  import oass_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // decoded sizes
  output logic OP32,
  output logic AD32,
  output logic STK32,
  output logic RET32
);
  oass_size_if sz ();
  logic [31:0] ctrl_reg;
  oass_mode_e mode_reg;
  logic pfx_op_reg;
  logic pfx_ad_reg;
  logic stk_reg;
  logic gate_use_reg;
  logic gate_32_reg;
  logic go_reg;
  logic [31:0] addr_reg;
  logic [31:0] limit_reg;
  logic [31:0] limchk_reg;
  logic valid_reg;
  logic op32_reg;
  logic ad32_reg;
  logic stk32_reg;
  logic ret32_reg;
  logic limok_reg;
  logic [31:0] ea_reg;
  logic stk32_w;
  logic [31:0] ea_w;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] rd_next;
  logic addr_ok;

  // size decoder
  assign sz.cs_d = ctrl_reg[`OASS_CTRL_CS_D];
  assign sz.mode = mode_reg;
  assign sz.pfx_op = pfx_op_reg;
  assign sz.pfx_ad = pfx_ad_reg;
  assign sz.gate_use = gate_use_reg;
  assign sz.gate_32 = gate_32_reg;
  oass_size_dec u_dec (
    .sz(sz.dec)
  );
  oass_stack_sel u_stk (
    .ss_b(ctrl_reg[`OASS_CTRL_SS_B]),
    .implicit_stk(stk_reg),
    .ad32(sz.size.ad32),
    .offset(addr_reg),
    .stk32(stk32_w),
    .ea(ea_w)
  );

  // expand-down valid range: above limit, below 64k or 4g top
  function automatic logic expdn_ok(input logic big, input logic [31:0] off,
                                    input logic [31:0] lim);
    logic [31:0] top;
    top = big ? `OASS_MASK32 : `OASS_MASK16;
    expdn_ok = (off > lim) && (off <= top);
  endfunction

  function automatic logic is_reg(input logic [31:0] a);
    is_reg = (a == `OASS_OFF_CTRL) || (a == `OASS_OFF_MODE) || (a == `OASS_OFF_INSN)
      || (a == `OASS_OFF_GATE) || (a == `OASS_OFF_ADDR) || (a == `OASS_OFF_LIMIT)
      || (a == `OASS_OFF_STAT) || (a == `OASS_OFF_EAOUT) || (a == `OASS_OFF_LIMCHK);
  endfunction

  // bus address phase capture
  wire bus_go = HSEL && HREADY && HTRANS[1];
  assign addr_ok = is_reg(HADDR);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= bus_go && HWRITE;
      if (bus_go) begin
        wr_addr_reg <= HADDR;
      end
    end
  end

  // read data registered in address phase
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (HADDR)
      `OASS_OFF_CTRL: rd_next = ctrl_reg;
      `OASS_OFF_MODE: rd_next = {30'h0000_0000, mode_reg};
      `OASS_OFF_INSN: rd_next = {28'h000_0000, stk_reg, 1'b0, pfx_ad_reg, pfx_op_reg};
      `OASS_OFF_GATE: rd_next = {30'h0000_0000, gate_32_reg, gate_use_reg};
      `OASS_OFF_STAT: rd_next = {24'h00_0000, limok_reg, pfx_ad_reg, pfx_op_reg, valid_reg,
                                 ret32_reg, stk32_reg, ad32_reg, op32_reg};
      `OASS_OFF_ADDR: rd_next = addr_reg;
      `OASS_OFF_EAOUT: rd_next = ea_reg;
      `OASS_OFF_LIMIT: rd_next = limit_reg;
      `OASS_OFF_LIMCHK: rd_next = limchk_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (bus_go && !HWRITE) begin
      HRDATA <= addr_ok ? rd_next : 32'h0000_0000;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // software configuration registers
  wire wr_en = wr_pend_reg;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= `OASS_RESET_CTRL;
      mode_reg <= OASS_MODE_REAL;
      gate_use_reg <= 1'b0;
      gate_32_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      limit_reg <= 32'h0000_0000;
    end else if (wr_en) begin
      unique case (wr_addr_reg)
        `OASS_OFF_CTRL: ctrl_reg <= {29'h0000_0000, HWDATA[2:0]};
        `OASS_OFF_MODE: mode_reg <= oass_mode_e'(HWDATA[1:0]);
        `OASS_OFF_GATE: begin
          gate_use_reg <= HWDATA[`OASS_GATE_USE];
          gate_32_reg <= HWDATA[`OASS_GATE_32];
        end
        `OASS_OFF_ADDR: addr_reg <= HWDATA;
        `OASS_OFF_LIMIT: limit_reg <= HWDATA;
        default: ;
      endcase
    end
  end

  // per-instruction prefixes; cleared once the instruction retires
  wire insn_wr = wr_en && (wr_addr_reg == `OASS_OFF_INSN);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pfx_op_reg <= 1'b0;
      pfx_ad_reg <= 1'b0;
      stk_reg <= 1'b0;
      go_reg <= 1'b0;
    end else if (insn_wr) begin
      pfx_op_reg <= HWDATA[`OASS_INSN_OPS];
      pfx_ad_reg <= HWDATA[`OASS_INSN_ADS];
      stk_reg <= HWDATA[`OASS_INSN_STK];
      go_reg <= HWDATA[`OASS_INSN_GO];
    end else if (go_reg) begin
      pfx_op_reg <= 1'b0;
      pfx_ad_reg <= 1'b0;
      stk_reg <= 1'b0;
      go_reg <= 1'b0;
    end
  end

  // result capture on instruction execute
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      valid_reg <= 1'b0;
      op32_reg <= 1'b0;
      ad32_reg <= 1'b0;
      stk32_reg <= 1'b0;
      ret32_reg <= 1'b0;
      ea_reg <= 32'h0000_0000;
      limok_reg <= 1'b0;
      limchk_reg <= 32'h0000_0000;
    end else if (go_reg) begin
      valid_reg <= 1'b1;
      op32_reg <= gate_use_reg ? gate_32_reg : sz.size.op32;
      ad32_reg <= sz.size.ad32;
      stk32_reg <= stk32_w;
      ret32_reg <= sz.xfer32;
      ea_reg <= ea_w;
      limok_reg <= expdn_ok(ctrl_reg[`OASS_CTRL_DS_B], ea_w, limit_reg);
      limchk_reg <= ctrl_reg[`OASS_CTRL_DS_B] ? `OASS_MASK32 : `OASS_MASK16;
    end
  end

  assign OP32 = op32_reg;
  assign AD32 = ad32_reg;
  assign STK32 = stk32_reg;
  assign RET32 = ret32_reg;
endmodule
`default_nettype wire

// ===== sim/oass_props.sv
// port checker for the size selector
`timescale 1ns/100ps
`default_nettype none
`include "oass_defines.svh"
module oass_props
  import oass_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // ahb-lite bus
  input wire logic HSEL,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HADDR,
  input wire logic [31:0] HWDATA,
  input wire logic [1:0] HTRANS,
  // decoded sizes
  input wire logic OP32,
  input wire logic AD32,
  input wire logic STK32,
  input wire logic RET32
);
  logic wr_q;
  logic [31:0] a_q;
  logic [2:0] ctrl_q;
  logic [1:0] mode_q, gate_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_q <= 1'b0;
      a_q <= 32'h0;
    end else if (HREADY) begin
      wr_q <= HSEL && HTRANS[1] && HWRITE;
      a_q <= HADDR;
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= 3'h0;
      mode_q <= 2'h0;
      gate_q <= 2'h0;
    end else if (wr_q) begin
      if (a_q == `OASS_OFF_CTRL) ctrl_q <= HWDATA[2:0];
      if (a_q == `OASS_OFF_MODE) mode_q <= HWDATA[1:0];
      if (a_q == `OASS_OFF_GATE) gate_q <= HWDATA[1:0];
    end
  end
  wire logic go = wr_q && a_q == `OASS_OFF_INSN && HWDATA[2];
  wire logic def32 = ctrl_q[0] && mode_q == OASS_MODE_PROT;
  wire logic eop = def32 ^ HWDATA[0];
  wire logic ead = def32 ^ HWDATA[1];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  a_op_default: assert property (go && !gate_q[0] |-> ##2 OP32 == $past(eop, 2))
    else $error("operand size wrong");
  a_ad_size: assert property (go && !gate_q[0] |-> ##2 AD32 == $past(ead, 2))
    else $error("address size wrong");
  a_native_16: assert property (go && mode_q != OASS_MODE_PROT &&
    HWDATA[1:0] == 2'h0 && !gate_q[0] |-> ##2 !OP32 && !AD32)
    else $error("native mode not 16-bit");
  a_stack_flag: assert property (go && HWDATA[3] |-> ##2 STK32 == $past(ctrl_q[1], 2))
    else $error("stack width wrong");
  a_explicit_stk: assert property (go && !HWDATA[3] |-> ##2 STK32 == $past(ead, 2))
    else $error("explicit stack width wrong");
  a_gate_size: assert property (go && gate_q[0] |-> ##2 OP32 == $past(gate_q[1], 2))
    else $error("gate operand size wrong");
  a_ret_width: assert property (go && gate_q[0] |-> ##2 RET32 == $past(gate_q[1], 2))
    else $error("return width wrong");
  a_one_insn: assert property (!$past(go) |=> $stable({OP32, AD32, STK32, RET32}))
    else $error("sizes changed without instruction");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  c_gate: cover property (go && gate_q[0]);
  c_implicit: cover property (go && HWDATA[3]);
  c_both_pfx: cover property (go && HWDATA[1:0] == 2'h3);
endmodule
bind oass_top oass_props chk_u (.CLK, .NRST, .HSEL, .HWRITE, .HREADY, .HREADYOUT, .HRESP,
  .HADDR, .HWDATA, .HTRANS, .OP32, .AD32, .STK32, .RET32);
`default_nettype wire

// ===== sim/oass_exec_model.sv
// execution unit model using the decoded operand size
`timescale 1ns/100ps
`default_nettype none
module oass_exec_model (
  // decoded sizes
  input wire logic OP32,
  // operand width in bits
  output logic [31:0] op_bits
);
  always_comb begin
    op_bits = OP32 ? 32'h20 : 32'h10;
  end
endmodule
`default_nettype wire

// ===== sim/oass_top_bench.sv
// self-checking bench for the size selector
`timescale 1ns/100ps
`default_nettype none
`include "oass_defines.svh"
module oass_top_bench;
  import oass_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA, rd, op_bits;
  logic HREADYOUT, HRESP, OP32, AD32, STK32, RET32, def, imp;
  int err_count = 0;
  int checked = 0;
  always #50 CLK = ~CLK;
  oass_top dut_u (.CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .OP32, .AD32, .STK32, .RET32);
  oass_exec_model far_u (.OP32, .op_bits);
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic edge_rdy;
    int n;
    n = 0;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("ERROR %0t: no ready", $time);
        end_of_test;
      end
      @(posedge CLK);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    edge_rdy;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    edge_rdy;
    rd = HRDATA;
  endtask
  task automatic go(input logic [31:0] ctrl, input logic [3:0] insn);
    xfer(1'b1, `OASS_OFF_CTRL, ctrl);
    xfer(1'b1, `OASS_OFF_INSN, {28'h0, insn | 4'h4});
    repeat (2) @(posedge CLK);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    cmp({OP32, AD32, STK32, RET32}, 32'h0);
    xfer(1'b0, 32'h0000_0040, 32'h0);
    cmp(rd, 32'h0);
    xfer(1'b1, `OASS_OFF_ADDR, 32'h0001_2345);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, `OASS_OFF_MODE, 32'(m));
      for (int k = 0; k < 16; k++) begin
        def = k[3] && m == 1;
        imp = k[1] ^ k[2];
        go({30'h0, k[2], k[3]}, {imp, 1'b0, k[1:0]});
        cmp({OP32, AD32}, {def ^ k[0], def ^ k[1]});
        cmp(op_bits, (def ^ k[0]) ? 32'h20 : 32'h10);
        if (imp) cmp(STK32, k[2]);
        if (!imp) cmp(STK32, def ^ k[1]);
        xfer(1'b0, `OASS_OFF_EAOUT, 32'h0);
        cmp(rd, (imp ? k[2] : def ^ k[1]) ? 32'h0001_2345 : 32'h0000_2345);
      end
    end
    xfer(1'b1, `OASS_OFF_MODE, 32'h1);
    for (int g = 0; g < 2; g++) begin
      xfer(1'b1, `OASS_OFF_GATE, {30'h0, g[0], 1'b1});
      go({31'h0, ~g[0]}, 4'h1);
      cmp({OP32, RET32}, {g[0], g[0]});
    end
    xfer(1'b1, `OASS_OFF_GATE, 32'h0);
    xfer(1'b1, `OASS_OFF_LIMIT, 32'h0000_1000);
    for (int b = 0; b < 2; b++) begin
      go({29'h0, b[0], 2'h3}, 4'h0);
      xfer(1'b0, `OASS_OFF_LIMCHK, 32'h0);
      cmp(rd, b[0] ? 32'hffff_ffff : 32'h0000_ffff);
      xfer(1'b0, `OASS_OFF_STAT, 32'h0);
      cmp(rd[7], b[0]);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
